/* File: bdcl_defines.svh */
`ifndef BDCL_DEFINES_SVH
`define BDCL_DEFINES_SVH
// Clock period and blanking scale
`define BDCL_CLK_PERIOD_NS 10
`define BDCL_BLANK_NS_PER_KOHM 5
// Blanking resistor range in kilohm
`define BDCL_RDLY_MIN_KOHM 8'h19
`define BDCL_RDLY_MAX_KOHM 8'h64
// Input comparator gain, 1.2 V expressed in mV
`define BDCL_IN_GAIN_MV 12'h04B0
// Output comparator divide and limit-pin clamp in mV
`define BDCL_OUT_DIV 4'hA
`define BDCL_LIMIT_CLAMP_MV 12'h03E8
// Limit pin rest level in mV when undriven
`define BDCL_LIMIT_REST_MV 12'h01F4
// Dead time between drives
`define BDCL_DEAD_NS 20
`define BDCL_DEAD_CYC ((`BDCL_DEAD_NS + `BDCL_CLK_PERIOD_NS - 1) / `BDCL_CLK_PERIOD_NS)
`endif

/* File: bdcl_pkg.sv */
`default_nettype none
package bdcl_pkg;
   typedef enum logic [1:0] {
      BDCL_HOLD = 2'b01,
      BDCL_RUN = 2'b10
   } bdcl_state_e;
   typedef struct packed {
      logic [11:0] hsDropMv;
      logic [11:0] outSenseMv;
   } bdcl_sense_s;
   typedef struct packed {
      logic [7:0] blankSetKohm;
      logic [7:0] senseSetKohm;
      logic [11:0] outputLimitSetMv;
      logic outputLimitDriven;
   } bdcl_cfg_s;
endpackage
`default_nettype wire

/* File: bdcl_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "bdcl_defines.svh"
// Function
// - Either comparator tripping after blanking ends high-side drive for this cycle.
// - Input comparator blanked from PWM rise; output comparator from both edges.
// - Blanking lasts about 5 ns per kilohm, resistor held within 25 to 100.
// - Output comparator uses the same blanking length as the input one.
// - Input threshold is 1.2 times sense resistor over blanking resistor.
// - Output threshold is one tenth of limit voltage, clamped at 0.1 V.
// - Fault flag rises together with the high-side cut.
// - Next PWM rise resumes switching while the flag stays set.
// - Flag clears at PWM rise only after a trip-free cycle.
// - Continuous output over-current gives zero duty until it drops.
// - A cut pulse makes the low side act as if the pulse ended.
// - Flag held high until supplies good, then low and commands accepted.
// - Low side off when disabled, else inverse of high side with dead time.
// - PWM command drives the high side directly, up to 2 MHz.
// - Under lockout both drives are held low.
module bdcl_top
   import bdcl_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic pwmCmd,
   input wire logic lowSideEnable,
   input wire logic suppliesGood,
   input wire bdcl_sense_s sense,
   input wire bdcl_cfg_s cfg,
   output logic highSideDrive,
   output logic lowSideDrive,
   output logic currentLimitFaultFlag
);
   bdcl_state_e state, next_state;
   logic pwmPrev, next_pwmPrev;
   logic [6:0] inBlankCnt, next_inBlankCnt, outBlankCnt, next_outBlankCnt;
   logic tripCycle, next_tripCycle, outTripCycle, next_outTripCycle;
   logic cutCycle, next_cutCycle, suppress, next_suppress;
   logic [1:0] deadCnt, next_deadCnt;
   logic next_highSideDrive, next_lowSideDrive, next_currentLimitFaultFlag;
   logic pwmRise, pwmFall, inBlank, outBlank, inOver, outOver, inTrip, outTrip, tripNow;
   logic hsWant, lsWant, running;
   logic [7:0] rdly;
   logic [6:0] blankCycles;
   logic [11:0] limitMv;

   // Clamp a kilohm setting into the allowed resistor range
   function automatic logic [7:0] clampKohm(input logic [7:0] r);
      if (r < `BDCL_RDLY_MIN_KOHM) begin
         clampKohm = `BDCL_RDLY_MIN_KOHM;
      end else if (r > `BDCL_RDLY_MAX_KOHM) begin
         clampKohm = `BDCL_RDLY_MAX_KOHM;
      end else begin
         clampKohm = r;
      end
   endfunction

   always_comb begin
      rdly = clampKohm(cfg.blankSetKohm);
      blankCycles = 7'((16'(rdly) * `BDCL_BLANK_NS_PER_KOHM + `BDCL_CLK_PERIOD_NS - 1) / `BDCL_CLK_PERIOD_NS);
      limitMv = cfg.outputLimitDriven ? cfg.outputLimitSetMv : `BDCL_LIMIT_REST_MV;
      pwmRise = pwmCmd && !pwmPrev;
      pwmFall = !pwmCmd && pwmPrev;
      inBlank = pwmRise || (inBlankCnt != 7'h00);
      outBlank = pwmRise || pwmFall || (outBlankCnt != 7'h00);
      inOver = (24'(sense.hsDropMv) * 24'(rdly)) > (24'(`BDCL_IN_GAIN_MV) * 24'(cfg.senseSetKohm));
      if (limitMv > `BDCL_LIMIT_CLAMP_MV) begin
         outOver = (16'(sense.outSenseMv) * `BDCL_OUT_DIV) > 16'(`BDCL_LIMIT_CLAMP_MV);
      end else begin
         outOver = (16'(sense.outSenseMv) * `BDCL_OUT_DIV) > 16'(limitMv);
      end
      running = (state == BDCL_RUN) && suppliesGood;
      inTrip = running && inOver && !inBlank;
      outTrip = running && outOver && !outBlank;
      tripNow = inTrip || outTrip;
   end

   always_comb begin
      next_state = state;
      unique case (state)
         BDCL_HOLD: begin
            if (suppliesGood) begin
               next_state = BDCL_RUN;
            end
         end
         BDCL_RUN: begin
            if (!suppliesGood) begin
               next_state = BDCL_HOLD;
            end
         end
      endcase
      next_pwmPrev = pwmCmd;
      // Same count loaded for both comparators
      next_inBlankCnt = pwmRise ? blankCycles - 7'h01 : (inBlankCnt != 7'h00 ? inBlankCnt - 7'h01 : inBlankCnt);
      next_outBlankCnt = (pwmRise || pwmFall) ? blankCycles - 7'h01 :
                         (outBlankCnt != 7'h00 ? outBlankCnt - 7'h01 : outBlankCnt);
      // Rise restarts the cycle, trip sets win
      next_tripCycle = tripNow || (tripCycle && !pwmRise && running);
      next_outTripCycle = outTrip || (outTripCycle && !pwmRise);
      next_cutCycle = tripNow || (cutCycle && !pwmRise);
      if (pwmRise) begin
         next_suppress = outTripCycle && outOver;
      end else begin
         next_suppress = suppress;
      end
      if (!suppliesGood) begin
         next_currentLimitFaultFlag = 1'b1;
      end else if (state != BDCL_RUN) begin
         next_currentLimitFaultFlag = 1'b0;
      end else if (tripNow) begin
         next_currentLimitFaultFlag = 1'b1;
      end else if (pwmRise) begin
         next_currentLimitFaultFlag = tripCycle;
      end else begin
         next_currentLimitFaultFlag = currentLimitFaultFlag;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state <= BDCL_HOLD;
         pwmPrev <= 1'b0;
         inBlankCnt <= 7'h00;
         outBlankCnt <= 7'h00;
         tripCycle <= 1'b0;
         outTripCycle <= 1'b0;
         cutCycle <= 1'b0;
         suppress <= 1'b0;
         currentLimitFaultFlag <= 1'b1;
      end else begin
         state <= next_state;
         pwmPrev <= next_pwmPrev;
         inBlankCnt <= next_inBlankCnt;
         outBlankCnt <= next_outBlankCnt;
         tripCycle <= next_tripCycle;
         outTripCycle <= next_outTripCycle;
         cutCycle <= next_cutCycle;
         suppress <= next_suppress;
         currentLimitFaultFlag <= next_currentLimitFaultFlag;
      end
   end

   always_comb begin
      hsWant = running && pwmCmd && !tripNow && !(cutCycle && !pwmRise) &&
               !(pwmRise ? (outTripCycle && outOver) : suppress);
      // Cut looks like normal pulse end
      lsWant = running && lowSideEnable && !hsWant;
      next_highSideDrive = hsWant && !lowSideDrive && (deadCnt == 2'h0);
      next_lowSideDrive = lsWant && !highSideDrive && (deadCnt == 2'h0);
      if ((highSideDrive && !next_highSideDrive) || (lowSideDrive && !next_lowSideDrive)) begin
         next_deadCnt = 2'(`BDCL_DEAD_CYC);
      end else if (deadCnt != 2'h0) begin
         next_deadCnt = deadCnt - 2'h1;
      end else begin
         next_deadCnt = deadCnt;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         highSideDrive <= 1'b0;
         lowSideDrive <= 1'b0;
         deadCnt <= 2'h0;
      end else begin
         highSideDrive <= next_highSideDrive;
         lowSideDrive <= next_lowSideDrive;
         deadCnt <= next_deadCnt;
      end
   end

   sequence s_trip;
      tripNow;
   endsequence
   sequence s_rise_clean;
      pwmRise && running && !tripCycle && !tripNow;
   endsequence

   a_trip_cuts_hs: assert property (@(posedge clk_sys) disable iff (!rstn)
      s_trip |=> !highSideDrive ##1 (!highSideDrive || $past(pwmRise))) else $error("high side not cut on trip");
   a_flag_on_trip: assert property (@(posedge clk_sys) disable iff (!rstn)
      s_trip |=> currentLimitFaultFlag) else $error("flag not set on trip");
   a_in_blank_rise: assert property (@(posedge clk_sys) disable iff (!rstn)
      pwmRise |-> !inTrip && !outTrip) else $error("trip not blanked at rise");
   a_out_blank_fall: assert property (@(posedge clk_sys) disable iff (!rstn)
      pwmFall && blankCycles > 7'h01 |=> !outTrip) else $error("output trip not blanked after fall");
   a_blank_same_len: assert property (@(posedge clk_sys) disable iff (!rstn)
      pwmRise |=> inBlankCnt == outBlankCnt) else $error("blank lengths differ");
   a_flag_kept: assert property (@(posedge clk_sys) disable iff (!rstn)
      pwmRise && running && tripCycle |=> currentLimitFaultFlag) else $error("flag dropped after trip cycle");
   a_flag_clears: assert property (@(posedge clk_sys) disable iff (!rstn)
      s_rise_clean |=> !currentLimitFaultFlag) else $error("flag not cleared after clean cycle");
   a_startup_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
      !suppliesGood |=> currentLimitFaultFlag && !highSideDrive && !lowSideDrive) else $error("start-up hold broken");
   a_flag_released: assert property (@(posedge clk_sys) disable iff (!rstn)
      state == BDCL_HOLD && suppliesGood |=> !currentLimitFaultFlag) else $error("flag not released at start-up");
   a_no_overlap: assert property (@(posedge clk_sys) disable iff (!rstn)
      !(highSideDrive && lowSideDrive)) else $error("drives overlap");
   a_ls_disabled: assert property (@(posedge clk_sys) disable iff (!rstn)
      !lowSideEnable |=> !lowSideDrive) else $error("low side on while disabled");
   a_zero_duty: assert property (@(posedge clk_sys) disable iff (!rstn)
      pwmRise && outTripCycle && outOver |=> !highSideDrive [*2]) else $error("pulse during over-current");
endmodule // bdcl_top
`default_nettype wire

/* File: bdcl_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
module bdcl_ctrl_model (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic run,
   input wire logic lsEn,
   input wire logic faultFlag,
   output logic pwmCmd,
   output logic lowSideEnable
);
   int cnt;
   logic flagSeenLow;
   // no pwm until flag seen low
   always @(negedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cnt <= 89;
         pwmCmd <= 1'b0;
         flagSeenLow <= 1'b0;
      end else if (!run || !flagSeenLow) begin
         cnt <= 89;
         pwmCmd <= 1'b0;
         flagSeenLow <= run && !faultFlag;
      end else begin
         cnt <= (cnt == 89) ? 0 : cnt + 1;
         pwmCmd <= (cnt == 89) || (cnt < 69);
      end
   end
   // low side held off on request
   always @(negedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         lowSideEnable <= 1'b0;
      end else begin
         lowSideEnable <= lsEn;
      end
   end
endmodule // bdcl_ctrl_model
`default_nettype wire

/* File: bdcl_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module bdcl_top_tb;
   import bdcl_pkg::*;
   logic clk_sys = 1'b0, rstn = 1'b0, run = 1'b0, lsEn = 1'b1, suppliesGood = 1'b0;
   logic pwmCmd, lowSideEnable, highSideDrive, lowSideDrive, currentLimitFaultFlag;
   bdcl_sense_s sense = '0;
   bdcl_cfg_s cfg = '0;
   int num_errors = 0, checks = 0, rDly, blank, hsOn, k, lim, outHi, outLo;
   bit tripQ[$];
   always #5 clk_sys = ~clk_sys;
   bdcl_ctrl_model bdcl_ctrl_model_inst (.clk_sys(clk_sys), .rstn(rstn), .run(run), .lsEn(lsEn),
      .faultFlag(currentLimitFaultFlag), .pwmCmd(pwmCmd), .lowSideEnable(lowSideEnable));
   bdcl_top bdcl_top_inst (.clk_sys(clk_sys), .rstn(rstn), .pwmCmd(pwmCmd), .lowSideEnable(lowSideEnable),
      .suppliesGood(suppliesGood), .sense(sense), .cfg(cfg), .highSideDrive(highSideDrive),
      .lowSideDrive(lowSideDrive), .currentLimitFaultFlag(currentLimitFaultFlag));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic close_out();
      if (num_errors == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // One pwm period against the model
   task automatic run_period(input int dropAt, input int dropLen, input logic [11:0] outMv, input bit trip,
      input int hsLo, input int hsHi);
      bit prev;
      prev = tripQ.pop_front();
      @(posedge pwmCmd);
      hsOn = 0;
      for (int i = 0; i < 89; i++) begin
         sense.hsDropMv = (i >= dropAt && i < dropAt + dropLen) ? 12'h0FFF : 12'h0000;
         sense.outSenseMv = outMv;
         @(posedge clk_sys);
         #1;
         if (highSideDrive === 1'b1) hsOn++;
         chk(highSideDrive & lowSideDrive, 1'b0);
         if (i == 2) chk(currentLimitFaultFlag, prev | !suppliesGood);
         @(negedge clk_sys);
      end
      chk(currentLimitFaultFlag, prev | trip | !suppliesGood);
      chk(lowSideDrive, lsEn & suppliesGood);
      chk(32'(hsOn >= hsLo && hsOn <= hsHi), 1);
      tripQ.push_back(trip);
   endtask
   initial begin
      k = $urandom(32'h28a4);
      rDly = 25 + $urandom % 66;
      blank = (rDly * 5 + 9) / 10;
      lim = 600 + $urandom % 401;
      outHi = lim / 10 + 2;
      outLo = lim / 10 - 2;
      cfg = '{8'(rDly), 8'(rDly), 12'(lim), 1'b1};
      tripQ = '{0};
      repeat (16) @(negedge clk_sys);
      chk({highSideDrive, lowSideDrive, currentLimitFaultFlag}, 3'b001);
      rstn <= 1'b1;
      run <= 1'b1;
      repeat (20) @(negedge clk_sys);
      chk(pwmCmd, 1'b0);
      chk({highSideDrive, lowSideDrive, currentLimitFaultFlag}, 3'b001);
      suppliesGood <= 1'b1;
      @(negedge clk_sys);
      chk(currentLimitFaultFlag, 1'b0);
      repeat (2) run_period(99, 0, 12'h0000, 0, 64, 70);
      run_period(1, blank - 1, 12'h0000, 0, 64, 70);
      k = blank + $urandom % 8;
      run_period(k, 70 - k, 12'h0000, 1, k - 4, k - 2);
      run_period(99, 0, 12'h0000, 0, 64, 70);
      run_period(99, 0, 12'h0000, 0, 64, 70);
      run_period(99, 0, 12'(outHi), 1, blank - 4, blank - 2);
      repeat (2) run_period(99, 0, 12'(outHi), 1, 0, 0);
      run_period(99, 0, 12'(outLo), 0, 64, 70);
      lsEn <= 1'b0;
      run_period(99, 0, 12'h0000, 0, 64, 70);
      cfg.outputLimitDriven = 1'b0;
      run_period(99, 0, 12'h0034, 1, blank - 1, blank + 1);
      rstn <= 1'b0;
      @(negedge clk_sys);
      chk({highSideDrive, lowSideDrive, currentLimitFaultFlag}, 3'b001);
      close_out();
   end
   initial begin
      repeat (5000) @(posedge clk_sys);
      num_errors++;
      close_out();
   end
endmodule // bdcl_top_tb
`default_nettype wire
